// ===== queue_pkg.sv
/*
 * Shared types and constants for the interlocked insert-at-head unit.
 * Assumes a 32-bit virtual address space and longword memory accesses.
 */
package queue_pkg;

    localparam logic [7:0]  OPC_INSERT_HEAD = 8'h5C;
    localparam logic [31:0] FWD_OFS         = 32'h0000_0000;
    localparam logic [31:0] BWD_OFS         = 32'h0000_0004;
    localparam int          LOCK_BIT        = 0;
    localparam logic [2:0]  ALIGN_MASK      = 3'h7;
    localparam logic [31:0] LOCK_ONE        = 32'h0000_0001;

    // Status and mask layout
    localparam int          ST_DONE         = 0;
    localparam int          ST_BUSY_FAIL    = 1;
    localparam int          ST_RSVD_FAULT   = 2;
    localparam int          ST_MM_FAULT     = 3;
    localparam int          ST_W            = 4;

    // Register map
    localparam logic [3:0]  REG_ENTRY       = 4'h0;
    localparam logic [3:0]  REG_HEADER      = 4'h1;
    localparam logic [3:0]  REG_CMD         = 4'h2;
    localparam logic [3:0]  REG_CC          = 4'h3;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_MASK        = 4'h5;
    localparam logic [3:0]  REG_STATE       = 4'h6;

    typedef enum logic [1:0] {
        MEM_READ,
        MEM_WRITE,
        MEM_PROBE
    } mem_op_e;

    typedef struct packed {
        logic        req;
        mem_op_e     op;
        logic        interlock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic [31:0] rdata;
    } mem_rsp_s;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } cc_s;

endpackage

// ===== queue_scratch.sv
/*
 * Small register file holding the longwords fetched during one insertion.
 * Assumes one write and one registered read per cycle.
 */
`timescale 1ns/1ps
module queue_scratch (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        we,
    input  wire logic [1:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  raddr,
    output logic      [31:0] rdata
);
    logic [31:0] mem_reg [4];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                mem_reg[i] <= 32'h0000_0000;
            end
            rdata <= 32'h0000_0000;
        end else begin
            if (we) begin
                mem_reg[waddr] <= wdata;
            end
            rdata <= mem_reg[raddr];
        end
    end
endmodule

// ===== insert_head_interlocked_op.sv
/*
 * Execution unit for the interlocked self-relative insert-at-head operation.
 * Assumes a memory port with req/done handshake; interlocked reads lock the
 * location until the next interlocked write to it. Probes check writability.
 */
`timescale 1ns/1ps
module insert_head_interlocked_op (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    output queue_pkg::mem_req_s     mem_req,
    input  wire queue_pkg::mem_rsp_s mem_rsp,
    output logic                    irq,
    output logic                    no_interrupt
);
    typedef enum logic [3:0] {
        S_IDLE,
        S_READ_HDR,
        S_RELEASE_BUSY,
        S_SET_LOCK,
        S_PROBE_ENTRY,
        S_PROBE_HEAD,
        S_WR_EFWD,
        S_WR_EBWD,
        S_WR_HBWD,
        S_WR_HDR,
        S_UNLOCK_FAULT
    } state_e;

    typedef struct packed {
        state_e                  st;
        logic [31:0]             entry;
        logic [31:0]             header;
        logic [31:0]             head_fwd;
        queue_pkg::cc_s          cc;
        logic [queue_pkg::ST_W-1:0] status;
        logic [queue_pkg::ST_W-1:0] mask;
        queue_pkg::mem_req_s     req;
        logic [31:0]             rdata;
        logic                    irq;
        logic                    busy;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic [31:0] scr_rdata;

    queue_scratch u_scratch (
        .clk   (clk),
        .nrst  (nrst),
        .we    (mem_rsp.done && s_reg.st == S_READ_HDR),
        .waddr (2'h0),
        .wdata (mem_rsp.rdata),
        .raddr (2'h0),
        .rdata (scr_rdata)
    );

    function automatic logic misaligned(input logic [31:0] a);
        misaligned = (a[2:0] & queue_pkg::ALIGN_MASK) != 3'h0;
    endfunction

    function automatic queue_pkg::mem_req_s issue(input queue_pkg::mem_op_e op, input logic lk,
                                                  input logic [31:0] a, input logic [31:0] d);
        issue.req       = 1'b1;
        issue.op        = op;
        issue.interlock = lk;
        issue.addr      = a;
        issue.wdata     = d;
    endfunction

    logic [31:0] head_addr;
    logic [queue_pkg::ST_W-1:0] ev;

    always_comb begin
        s_next = s_reg;
        ev = '0;
        head_addr = s_reg.header + s_reg.head_fwd;
        s_next.req.req = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                queue_pkg::REG_ENTRY: begin
                    if (!s_reg.busy) begin
                        s_next.entry = reg_wdata;
                    end
                end
                queue_pkg::REG_HEADER: begin
                    if (!s_reg.busy) begin
                        s_next.header = reg_wdata;
                    end
                end
                queue_pkg::REG_MASK: s_next.mask = reg_wdata[queue_pkg::ST_W-1:0];
                queue_pkg::REG_STATUS: s_next.status = s_reg.status & ~reg_wdata[queue_pkg::ST_W-1:0];
                default: ;
            endcase
        end
        case (s_reg.st)
            S_IDLE: begin
                if (reg_wr && reg_addr == queue_pkg::REG_CMD
                    && reg_wdata[7:0] == queue_pkg::OPC_INSERT_HEAD) begin
                    if (misaligned(s_reg.entry) || misaligned(s_reg.header)
                        || s_reg.entry == s_reg.header) begin
                        ev[queue_pkg::ST_RSVD_FAULT] = 1'b1;
                    end else begin
                        s_next.busy = 1'b1;
                        s_next.st = S_READ_HDR;
                        s_next.req = issue(queue_pkg::MEM_READ, 1'b1, s_reg.header, '0);
                    end
                end
            end
            S_READ_HDR: begin
                if (mem_rsp.done) begin
                    s_next.head_fwd = mem_rsp.rdata;
                    if (mem_rsp.rdata[queue_pkg::LOCK_BIT]) begin
                        s_next.st = S_RELEASE_BUSY;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b1, s_reg.header, mem_rsp.rdata);
                    end else if (mem_rsp.rdata[2:1] != 2'h0) begin
                        s_next.st = S_RELEASE_BUSY;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b1, s_reg.header, mem_rsp.rdata);
                    end else begin
                        s_next.st = S_SET_LOCK;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b1, s_reg.header,
                                           mem_rsp.rdata | queue_pkg::LOCK_ONE);
                    end
                end
            end
            S_RELEASE_BUSY: begin
                if (mem_rsp.done) begin
                    s_next.st = S_IDLE;
                    s_next.busy = 1'b0;
                    if (s_reg.head_fwd[queue_pkg::LOCK_BIT]) begin
                        s_next.cc = '{n: 1'b0, z: 1'b0, v: 1'b0, c: 1'b1};
                        ev[queue_pkg::ST_BUSY_FAIL] = 1'b1;
                    end else begin
                        ev[queue_pkg::ST_RSVD_FAULT] = 1'b1;
                    end
                end
            end
            S_SET_LOCK: begin
                if (mem_rsp.done) begin
                    s_next.st = S_PROBE_ENTRY;
                    s_next.req = issue(queue_pkg::MEM_PROBE, 1'b0, s_reg.entry, '0);
                end
            end
            S_PROBE_ENTRY: begin
                if (mem_rsp.done) begin
                    if (mem_rsp.fault || misaligned(head_addr)) begin
                        s_next.st = S_UNLOCK_FAULT;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, s_reg.header, s_reg.head_fwd);
                    end else begin
                        s_next.st = S_PROBE_HEAD;
                        s_next.req = issue(queue_pkg::MEM_PROBE, 1'b0, head_addr + queue_pkg::BWD_OFS, '0);
                    end
                end
            end
            S_PROBE_HEAD: begin
                if (mem_rsp.done) begin
                    if (mem_rsp.fault) begin
                        s_next.st = S_UNLOCK_FAULT;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, s_reg.header, s_reg.head_fwd);
                    end else begin
                        s_next.st = S_WR_EFWD;
                        s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, s_reg.entry + queue_pkg::FWD_OFS,
                                           head_addr - s_reg.entry);
                    end
                end
            end
            S_WR_EFWD: begin
                if (mem_rsp.done) begin
                    s_next.st = S_WR_EBWD;
                    s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, s_reg.entry + queue_pkg::BWD_OFS,
                                       s_reg.header - s_reg.entry);
                end
            end
            S_WR_EBWD: begin
                if (mem_rsp.done) begin
                    s_next.st = S_WR_HBWD;
                    s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, head_addr + queue_pkg::BWD_OFS,
                                       s_reg.entry - head_addr);
                end
            end
            S_WR_HBWD: begin
                if (mem_rsp.done) begin
                    s_next.st = S_WR_HDR;
                    // Header write also clears the secondary lock
                    s_next.req = issue(queue_pkg::MEM_WRITE, 1'b0, s_reg.header + queue_pkg::FWD_OFS,
                                       s_reg.entry - s_reg.header);
                end
            end
            S_WR_HDR: begin
                if (mem_rsp.done) begin
                    s_next.st = S_IDLE;
                    s_next.busy = 1'b0;
                    // Entry links equal only when head was the header itself
                    s_next.cc = '{n: 1'b0, z: (head_addr == s_reg.header), v: 1'b0, c: 1'b0};
                    ev[queue_pkg::ST_DONE] = 1'b1;
                end
            end
            S_UNLOCK_FAULT: begin
                if (mem_rsp.done) begin
                    s_next.st = S_IDLE;
                    s_next.busy = 1'b0;
                    ev[queue_pkg::ST_MM_FAULT] = 1'b1;
                end
            end
            default: s_next.st = S_IDLE;
        endcase
        // Events win over a same-cycle clear
        s_next.status = s_next.status | ev;
        s_next.irq = |(s_next.status & s_next.mask);
        s_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                queue_pkg::REG_ENTRY:  s_next.rdata = s_reg.entry;
                queue_pkg::REG_HEADER: s_next.rdata = s_reg.header;
                queue_pkg::REG_CC:     s_next.rdata = {28'h000_0000, s_reg.cc};
                queue_pkg::REG_STATUS: s_next.rdata = {28'h000_0000, s_reg.status};
                queue_pkg::REG_MASK:   s_next.rdata = {28'h000_0000, s_reg.mask};
                queue_pkg::REG_STATE:  s_next.rdata = {31'h0000_0000, s_reg.busy};
                default:               s_next.rdata = scr_rdata & 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign mem_req = s_reg.req;
    assign irq = s_reg.irq;
    assign no_interrupt = s_reg.busy;
endmodule

// ===== insert_head_props.sv
/*
 * Port-level checker for the interlocked insert-at-head unit.
 * Assumes one memory request outstanding at a time and the bind below.
 */
`timescale 1ns/1ps
module insert_head_props (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic [3:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire queue_pkg::mem_req_s  mem_req,
    input wire queue_pkg::mem_rsp_s  mem_rsp,
    input wire logic                 irq,
    input wire logic                 no_interrupt
);
    logic                outst;
    logic                after_rd;
    logic                pfault;
    logic [31:0]         rd_a;
    logic [31:0]         rd_d;
    logic [2:0]          probes;
    queue_pkg::mem_op_e  cur_op;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {outst, after_rd, pfault, rd_a, rd_d, probes} <= '0;
            cur_op <= queue_pkg::MEM_READ;
        end else if (mem_req.req) begin
            outst <= 1'b1;
            cur_op <= mem_req.op;
            after_rd <= 1'b0;
            pfault <= 1'b0;
            if (mem_req.op == queue_pkg::MEM_READ) begin
                rd_a <= mem_req.addr;
                probes <= 3'h0;
            end
        end else if (mem_rsp.done && outst) begin
            outst <= 1'b0;
            after_rd <= cur_op == queue_pkg::MEM_READ;
            pfault <= cur_op == queue_pkg::MEM_PROBE && mem_rsp.fault;
            if (cur_op == queue_pkg::MEM_READ) begin
                rd_d <= mem_rsp.rdata;
            end
            if (cur_op == queue_pkg::MEM_PROBE && !mem_rsp.fault && probes != 3'h7) begin
                probes <= probes + 3'h1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_req_pulse: assert property (mem_req.req |=> !mem_req.req) else $error("request held too long");
    chk_single_outst: assert property (mem_req.req |-> !outst)
        else $error("second request while one outstanding");
    chk_read_locked: assert property (mem_req.req && mem_req.op == queue_pkg::MEM_READ |-> mem_req.interlock)
        else $error("header read without interlock");
    chk_hdr_writeback: assert property (mem_req.req && after_rd |-> mem_req.op == queue_pkg::MEM_WRITE
        && mem_req.interlock && mem_req.addr == rd_a) else $error("header not written back after locked read");
    chk_lock_set: assert property (mem_req.req && after_rd && rd_d[2:0] == 3'h0
        |-> mem_req.wdata == (rd_d | queue_pkg::LOCK_ONE)) else $error("secondary lock not set");
    chk_locked_same: assert property (mem_req.req && after_rd && rd_d[0] |-> mem_req.wdata == rd_d)
        else $error("locked header altered");
    chk_probe_first: assert property (mem_req.req && mem_req.op == queue_pkg::MEM_WRITE
        && mem_req.addr != rd_a |-> probes >= 3'h2) else $error("queue written before probes");
    chk_fault_restore: assert property (mem_req.req && pfault |-> mem_req.op == queue_pkg::MEM_WRITE
        && mem_req.addr == rd_a && mem_req.wdata == rd_d) else $error("header not restored on probe fault");
    chk_busy_holdoff: assert property (mem_req.req |-> no_interrupt)
        else $error("memory request while interruptible");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside slot");
    cov_fault: cover property (mem_req.req && pfault);
    cov_locked: cover property (mem_req.req && after_rd && rd_d[0]);
    cov_irq: cover property ($rose(irq));
endmodule
bind insert_head_interlocked_op insert_head_props insert_head_props_inst (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .irq(irq), .no_interrupt(no_interrupt));

// ===== mem_model.sv
/*
 * Shared memory model answering one request after a chosen delay.
 * Assumes longword addresses below 0x100 and a single requesting unit.
 */
`timescale 1ns/1ps
module mem_model (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire queue_pkg::mem_req_s mem_req,
    input  wire logic [31:0]         fault_addr,
    input  wire logic [3:0]          dly,
    output queue_pkg::mem_rsp_s      mem_rsp
);
    logic [31:0]         mem [0:63];
    queue_pkg::mem_req_s q;
    logic                busy;
    logic [3:0]          left;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {busy, left, q, mem_rsp} <= '0;
        end else begin
            mem_rsp.done <= 1'b0;
            mem_rsp.fault <= 1'b0;
            // Idle data line keeps changing so a stale word is never trusted
            mem_rsp.rdata <= ~mem_rsp.rdata;
            if (mem_req.req) begin
                busy <= 1'b1;
                left <= dly;
                q <= mem_req;
            end else if (busy && left != 4'h0) begin
                left <= left - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                mem_rsp.done <= 1'b1;
                // Only one master, so the locked read is atomic by itself
                if (q.op == queue_pkg::MEM_READ) mem_rsp.rdata <= mem[q.addr[7:2]];
                if (q.op == queue_pkg::MEM_PROBE) mem_rsp.fault <= q.addr == fault_addr;
            end
        end
    end
    always @(posedge clk) begin
        if (busy && left == 4'h0 && q.op == queue_pkg::MEM_WRITE) mem[q.addr[7:2]] <= q.wdata;
    end
endmodule

// ===== testbench.sv
/*
 * Register-level tests of the insert-at-head unit against the memory model.
 * Assumes the register map and status layout of the package.
 */
`timescale 1ns/1ps
module testbench;
    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [3:0]          reg_addr = 4'h0;
    logic [3:0]          dly = 4'h0;
    logic [3:0]          mask_v = 4'h0;
    logic [31:0]         reg_wdata = 32'h0000_0000;
    logic [31:0]         fault_addr = 32'hFFFF_FFFF;
    logic [31:0]         reg_rdata;
    logic [31:0]         rd_v;
    logic                irq;
    logic                no_interrupt;
    queue_pkg::mem_req_s mem_req;
    queue_pkg::mem_rsp_s mem_rsp;
    int                  err_count = 0;
    int                  checked = 0;
    logic [31:0]         te [4] = '{32'h0000_0084, 32'h0000_0040, 32'h0000_00C0, 32'h0000_00C0};
    logic [31:0]         th [4] = '{32'h0000_0040, 32'h0000_0040, 32'h0000_0040, 32'h0000_0044};
    logic [31:0]         tv [4] = '{32'hFFFF_FFE0, 32'hFFFF_FFE0, 32'hFFFF_FFE2, 32'hFFFF_FFE0};
    always #2.5 clk = ~clk;
    insert_head_interlocked_op insert_head_interlocked_op_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .irq(irq), .no_interrupt(no_interrupt));
    mem_model mem_model_inst (.clk(clk), .nrst(nrst), .mem_req(mem_req), .fault_addr(fault_addr), .dly(dly),
        .mem_rsp(mem_rsp));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input string n, input logic [31:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        if (n != "") check(n, rd_v, e);
    endtask
    task automatic mc(input logic [31:0] a, input logic [31:0] e);
        check($sformatf("mem %h", a), mem_model_inst.mem[a[7:2]], e);
    endtask
    task automatic run(input logic [31:0] e, input logic [31:0] h, input logic [3:0] st, input logic slow);
        int i;
        wr(queue_pkg::REG_ENTRY, e);
        wr(queue_pkg::REG_HEADER, h);
        wr(queue_pkg::REG_CMD, 32'h0000_005C);
        if (slow) begin
            rc(queue_pkg::REG_STATE, "", 32'h0);
            check("busy", {31'h0, rd_v[0]}, 32'h0000_0001);
            check("no_interrupt busy", {31'h0, no_interrupt}, 32'h0000_0001);
            wr(queue_pkg::REG_ENTRY, 32'h0000_00F8);
        end
        rd_v = 32'h0;
        for (i = 0; i < 100 && rd_v[3:0] === 4'h0; i++) rc(queue_pkg::REG_STATUS, "", 32'h0);
        check("status", rd_v, {28'h0, st});
        check("irq", {31'h0, irq}, {31'h0, |(st & mask_v)});
        check("no_interrupt idle", {31'h0, no_interrupt}, 32'h0);
        rc(queue_pkg::REG_ENTRY, "entry kept", e);
    endtask
    task automatic clr();
        wr(queue_pkg::REG_STATUS, 32'h0000_000F);
        rc(queue_pkg::REG_STATUS, "status cleared", 32'h0);
        check("irq off", {31'h0, irq}, 32'h0);
    endtask
    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        conclude();
    end
    initial begin
        // Entries and header stay quadword aligned except where a fault is wanted
        // Queues are kept well formed and never overlap, except the reserved tests with header link FFFFFFE2 or entry equal to header
        for (int i = 0; i < 64; i++) mem_model_inst.mem[i] = 32'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rc(queue_pkg::REG_STATUS, "status reset", 32'h0);
        rc(queue_pkg::REG_STATE, "state reset", 32'h0);
        run(32'h0000_0080, 32'h0000_0040, 4'h1, 1'b0);
        rc(queue_pkg::REG_CC, "cc empty", 32'h0000_0004);
        mc(32'h80, 32'hFFFF_FFC0); mc(32'h84, 32'hFFFF_FFC0); mc(32'h40, 32'h40); mc(32'h44, 32'h40);
        clr();
        run(32'h0000_0020, 32'h0000_0040, 4'h1, 1'b0);
        rc(queue_pkg::REG_CC, "cc nonempty", 32'h0);
        mc(32'h20, 32'h60); mc(32'h24, 32'h20); mc(32'h84, 32'hFFFF_FFA0); mc(32'h40, 32'hFFFF_FFE0);
        clr();
        $display("insert tests done");
        mem_model_inst.mem[16] = 32'hFFFF_FFE1;
        dly = 4'h6;
        run(32'h0000_00C0, 32'h0000_0040, 4'h2, 1'b1);
        rc(queue_pkg::REG_CC, "cc locked", 32'h0000_0001);
        mc(32'h40, 32'hFFFF_FFE1); mc(32'hC0, 32'h0);
        clr();
        dly = 4'h0;
        $display("locked test done");
        for (int k = 0; k < 4; k++) begin
            mem_model_inst.mem[16] = tv[k];
            run(te[k], th[k], 4'h4, 1'b0);
            mc(32'h40, tv[k]); mc(32'hC0, 32'h0);
            clr();
        end
        mem_model_inst.mem[16] = 32'hFFFF_FFE0;
        $display("reserved tests done");
        mem_model_inst.mem[40] = 32'h1234_5678;
        fault_addr = 32'h0000_00A0;
        wr(queue_pkg::REG_MASK, 32'h0000_0008);
        mask_v = 4'h8;
        run(32'h0000_00A0, 32'h0000_0040, 4'h8, 1'b0);
        mc(32'h40, 32'hFFFF_FFE0); mc(32'hA0, 32'h1234_5678); mc(32'h24, 32'h20);
        clr();
        wr(4'hF, 32'hFFFF_FFFF);
        rc(queue_pkg::REG_MASK, "mask", 32'h0000_0008);
        $display("fault and interrupt tests done");
        conclude();
    end
endmodule
